// [hw/charger_control_status_regs.v]
`include "charger_regs_consts.vh"
module charger_control_status_regs #(
  parameter [31:0] TICKS_PER_SEC = `CLK_HZ
)(
  input wire ref_clk,
  input wire resetn,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [1:0] dog_limit_sel,
  input wire [2:0] charge_phase,
  input wire power_path_active,
  input wire input_power_good,
  input wire thermal_regulating,
  input wire input_fault_flag,
  input wire overheat_shutdown_flag,
  input wire battery_overvolt_flag,
  input wire safety_timeout_flag,
  input wire [2:0] thermistor_fault_code,
  input wire pg_irq_src,
  input wire eoc_irq_src,
  input wire phase_irq_src,
  input wire therm_irq_src,
  input wire bovp_irq_src,
  output wire pg_irq,
  output wire eoc_irq,
  output wire phase_irq,
  output wire therm_irq,
  output wire bovp_irq,
  output wire battery_switch_on,
  output wire safety_timer_double_en,
  output wire low_power_enable,
  output wire input_loop_disable,
  output wire [1:0] junction_limit_sel,
  output wire [3:0] system_voltage_code,
  output wire [15:0] system_voltage_mv,
  output wire register_reset_req,
  output wire dog_expiry_event
);
  // status inputs come from analog comparators, so synchronise them
  reg [19:0] stat_s1_q; // first stage, read by second stage only
  reg [19:0] stat_s2_q; // second stage, safe to use
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      stat_s1_q <= 20'h00000;
      stat_s2_q <= 20'h00000;
    end
    else
    begin
      stat_s1_q <= {charge_phase, power_path_active, input_power_good,
                    thermal_regulating, input_fault_flag, overheat_shutdown_flag,
                    battery_overvolt_flag, safety_timeout_flag,
                    thermistor_fault_code, pg_irq_src, eoc_irq_src,
                    phase_irq_src, therm_irq_src, bovp_irq_src,
                    dog_limit_sel};
      stat_s2_q <= stat_s1_q;
    end
  end

  // named views of the synchronised inputs
  wire [2:0] phase_s = stat_s2_q[19:17];
  wire ppm_s = stat_s2_q[16];
  wire pg_s = stat_s2_q[15];
  wire therm_reg_s = stat_s2_q[14];
  wire input_fault_flag_s = stat_s2_q[13];
  wire hot_sd_s = stat_s2_q[12];
  wire bovp_s = stat_s2_q[11];
  wire stmr_s = stat_s2_q[10];
  wire [2:0] ntc_s = stat_s2_q[9:7];
  wire [4:0] irq_src_s = stat_s2_q[6:2];
  wire [1:0] dog_sel_s = stat_s2_q[1:0];

  // writable registers
  reg [7:0] fet_mask_q; // fet_and_irq_mask_ctrl
  reg [7:0] pwr_ctrl_q; // power_mode_thermal_sysv_ctrl
  reg reg_reset_q; // register reset request bit
  reg dog_fault_q; // sticky watchdog expiry flag
  wire dog_expired; // one-cycle expiry pulse
  wire wr_fet = reg_wr && (reg_addr == `OFS_FET_MASK);
  wire wr_pwr = reg_wr && (reg_addr == `OFS_POWER_CTRL);
  wire wr_flt = reg_wr && (reg_addr == `OFS_OP_FAULTS);
  wire dog_restart = wr_fet && reg_wdata[`BIT_DOG_RESTART];
  // a register reset restores every writable field, one cycle after the request
  wire soft_reset = reg_reset_q;

  // fet/mask register: watchdog expiry resets all but the switch bit
  always @(posedge ref_clk)
  begin
    if (!resetn || soft_reset)
      fet_mask_q <= `RST_FET_MASK;
    else if (dog_expired)
      fet_mask_q <= {`RST_FET_MASK & 8'hDF} | {2'b00, fet_mask_q[5], 5'h00};
    else if (wr_fet)
      fet_mask_q <= {1'b0, reg_wdata[6:0]};
    else
      fet_mask_q[`BIT_DOG_RESTART] <= 1'b0;
  end

  // power control: expiry resets only the input loop and junction fields
  always @(posedge ref_clk)
  begin
    if (!resetn || soft_reset)
      pwr_ctrl_q <= `RST_POWER_CTRL;
    else if (dog_expired)
      // low-power and system voltage survive expiry so the load is not disturbed
      pwr_ctrl_q <= (pwr_ctrl_q & 8'h8F) | (`RST_POWER_CTRL & 8'h70);
    else if (wr_pwr)
      pwr_ctrl_q <= reg_wdata;
  end

  // register reset bit: host sets it, a register reset clears it, expiry does not
  always @(posedge ref_clk)
  begin
    if (!resetn || soft_reset)
      reg_reset_q <= 1'b0;
    else if (wr_flt)
      reg_reset_q <= reg_wdata[`BIT_REG_RESET];
  end

  // sticky expiry flag; set wins over the restart that clears it
  always @(posedge ref_clk)
  begin
    if (!resetn)
      dog_fault_q <= 1'b0;
    else if (dog_expired)
      dog_fault_q <= 1'b1;
    else if (dog_restart)
      dog_fault_q <= 1'b0;
  end

  dog_timer #(
    .TICKS_PER_SEC(TICKS_PER_SEC)
  ) u_dog (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .limit_sel(dog_sel_s),
    .restart(dog_restart),
    .expired(dog_expired)
  );

  sysv_decode u_sysv (
    .code(pwr_ctrl_q[3:0]),
    .millivolts(system_voltage_mv)
  );

  // masked interrupt outputs: a mask bit of 1 blocks the source
  assign pg_irq = irq_src_s[4] & ~fet_mask_q[`BIT_PG_MASK];
  assign eoc_irq = irq_src_s[3] & ~fet_mask_q[`BIT_EOC_MASK];
  assign phase_irq = irq_src_s[2] & ~fet_mask_q[`BIT_PHASE_MASK];
  assign therm_irq = irq_src_s[1] & ~fet_mask_q[`BIT_THERM_MASK];
  assign bovp_irq = irq_src_s[0] & ~fet_mask_q[`BIT_BOVP_MASK];
  // control outputs
  assign battery_switch_on = ~fet_mask_q[`BIT_SWITCH_OFF];
  assign safety_timer_double_en = fet_mask_q[`BIT_TIMER_DOUBLE];
  assign low_power_enable = pwr_ctrl_q[`BIT_LOW_POWER];
  assign input_loop_disable = pwr_ctrl_q[`BIT_INPUT_LOOP];
  assign junction_limit_sel = pwr_ctrl_q[`POS_JUNCTION+1:`POS_JUNCTION];
  assign system_voltage_code = pwr_ctrl_q[`POS_SYSV+3:`POS_SYSV];
  assign register_reset_req = reg_reset_q;
  assign dog_expiry_event = dog_expired;

  // read data registered one cycle after the read strobe
  always @(posedge ref_clk)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `OFS_FET_MASK: reg_rdata <= fet_mask_q;
        `OFS_POWER_CTRL: reg_rdata <= pwr_ctrl_q;
        `OFS_OP_STATUS: reg_rdata <= {dog_fault_q, 1'b0, phase_s, ppm_s, pg_s,
                                      therm_reg_s};
        `OFS_OP_FAULTS: reg_rdata <= {reg_reset_q, input_fault_flag_s, hot_sd_s, bovp_s,
                                      stmr_s, ntc_s};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// [hw/charger_regs_consts.vh]
`ifndef CHARGER_REGS_CONSTS_VH
`define CHARGER_REGS_CONSTS_VH
// register offsets on the serial register port
`define OFS_FET_MASK 8'h06
`define OFS_POWER_CTRL 8'h07
`define OFS_OP_STATUS 8'h08
`define OFS_OP_FAULTS 8'h09
// fet_and_irq_mask_ctrl fields
`define BIT_DOG_RESTART 7
`define BIT_TIMER_DOUBLE 6
`define BIT_SWITCH_OFF 5
`define BIT_PG_MASK 4
`define BIT_EOC_MASK 3
`define BIT_PHASE_MASK 2
`define BIT_THERM_MASK 1
`define BIT_BOVP_MASK 0
`define RST_FET_MASK 8'h40
// power_mode_thermal_sysv_ctrl fields
`define BIT_LOW_POWER 7
`define BIT_INPUT_LOOP 6
`define POS_JUNCTION 4
`define POS_SYSV 0
`define RST_POWER_CTRL 8'h39
// status and fault fields
`define BIT_DOG_FAULT 7
`define POS_PHASE 3
`define BIT_REG_RESET 7
// watchdog limit codes and times
`define DOG_OFF 2'h0
`define DOG_40S 2'h1
`define DOG_80S 2'h2
`define DOG_160S 2'h3
`define DOG_BASE_S 40
`define CLK_HZ 20000000
// system voltage: base and step in millivolts
`define SYSV_BASE_MV 16'h1068
`define SYSV_STEP_MV 16'h0032
`endif

// [hw/dog_timer.v]
`include "charger_regs_consts.vh"
// serial watchdog: counts whole seconds, then seconds up to the limit
module dog_timer #(
  parameter [31:0] TICKS_PER_SEC = `CLK_HZ
)(
  input wire ref_clk,
  input wire resetn,
  input wire [1:0] limit_sel,
  input wire restart,
  output reg expired
);
  reg [31:0] tick_q; // cycles within the current second
  reg [7:0] sec_q; // elapsed seconds
  wire [7:0] limit_sec; // limit from the select code
  assign limit_sec = (limit_sel == `DOG_40S) ? 8'h28 :
                     (limit_sel == `DOG_80S) ? 8'h50 : 8'hA0;
  // a disabled timer holds at zero so re-enable starts a full period
  always @(posedge ref_clk)
  begin
    if (!resetn || restart || limit_sel == `DOG_OFF)
    begin
      tick_q <= 32'h0;
      sec_q <= 8'h0;
      expired <= 1'b0;
    end
    else if (sec_q >= limit_sec)
    begin
      expired <= 1'b1; // one pulse, then restart counting
      tick_q <= 32'h0;
      sec_q <= 8'h0;
    end
    else
    begin
      expired <= 1'b0;
      if (tick_q == TICKS_PER_SEC - 32'h1)
      begin
        tick_q <= 32'h0;
        sec_q <= sec_q + 8'h1;
      end
      else
        tick_q <= tick_q + 32'h1;
    end
  end
endmodule

// [hw/sysv_decode.v]
`include "charger_regs_consts.vh"
// system voltage target in millivolts from the four-bit code
module sysv_decode (
  input wire [3:0] code,
  output wire [15:0] millivolts
);
  // binary weighted steps of 50 mV above the 4.2 V base
  assign millivolts = `SYSV_BASE_MV + `SYSV_STEP_MV * {12'h000, code};
endmodule

// [verification/charger_regs_monitor.sv]
// port-level checks on the register bank; watches design ports only
module charger_regs_monitor (
  input wire ref_clk,
  input wire resetn,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire pg_irq_src,
  input wire pg_irq,
  input wire battery_switch_on,
  input wire low_power_enable,
  input wire [1:0] junction_limit_sel,
  input wire [3:0] system_voltage_code,
  input wire [15:0] system_voltage_mv,
  input wire register_reset_req,
  input wire dog_expiry_event
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  reset_values_a: assert property ($rose(resetn) |-> junction_limit_sel == 2'h3 &&
    system_voltage_code == 4'h9 && !low_power_enable && battery_switch_on)
    else $error("bad control value after reset");
  sysv_scale_a: assert property (system_voltage_mv == 16'h1068 + 16'h0032 * system_voltage_code)
    else $error("system voltage not base plus steps");
  switch_write_a: assert property (reg_wr && reg_addr == 8'h06 |=>
    battery_switch_on == !$past(reg_wdata[5])) else $error("switch does not follow write");
  power_write_a: assert property (reg_wr && reg_addr == 8'h07 |=>
    low_power_enable == $past(reg_wdata[7]) && junction_limit_sel == $past(reg_wdata[5:4]))
    else $error("power control does not follow write");
  irq_mask_a: assert property (pg_irq |-> $past(pg_irq_src, 2))
    else $error("interrupt without source");
  unmapped_zero_a: assert property ($past(reg_rd && (reg_addr < 8'h06 || reg_addr > 8'h09)) |->
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  expiry_pulse_a: assert property (dog_expiry_event |=> !dog_expiry_event)
    else $error("expiry event longer than one cycle");
  reg_reset_a: assert property (register_reset_req |=> !register_reset_req &&
    system_voltage_code == 4'h9 && battery_switch_on) else $error("register reset incomplete");
endmodule

bind charger_control_status_regs charger_regs_monitor i_mon (.*);

// [verification/charger_host.sv]
// host on the register port: one strobe per access, lines scrambled when idle
module charger_host (
  input wire ref_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // strobe held for exactly one sampling edge; writes requests too
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    #5 {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge ref_clk);
    #5 q = reg_rdata;
    // idle lines show garbage so nothing relies on stale values
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
  endtask
endmodule

// [verification/charger_control_status_regs_tb.sv]
module charger_control_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, resetn = 0, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic [1:0] dog_limit_sel = 2'h0, junction_limit_sel;
  logic [2:0] charge_phase = 3'h0, thermistor_fault_code = 3'h0;
  logic power_path_active = 0, input_power_good = 0, thermal_regulating = 0;
  logic input_fault_flag = 0, overheat_shutdown_flag = 0, battery_overvolt_flag = 0;
  logic safety_timeout_flag = 0, pg_irq_src = 1, eoc_irq_src = 1, phase_irq_src = 1;
  logic therm_irq_src = 1, bovp_irq_src = 1, pg_irq, eoc_irq, phase_irq, therm_irq, bovp_irq;
  logic battery_switch_on, safety_timer_double_en, low_power_enable, input_loop_disable;
  logic [3:0] system_voltage_code;
  logic [15:0] system_voltage_mv;
  logic register_reset_req, dog_expiry_event;
  int err_total = 0, samples_checked = 0, n;
  charger_control_status_regs #(.TICKS_PER_SEC(10)) i_dut (.*);
  charger_host i_host (.*);
  initial forever #25 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.acc(1'h1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    i_host.acc(1'h0, a, 8'h00, q);
    chk("rdata", q, e);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    end_sim();
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #5 resetn = 1;
    rc(8'h06, 8'h40);
    rc(8'h07, 8'h39);
    rc(8'h08, 8'h00);
    rc(8'h09, 8'h00);
    chk("double", safety_timer_double_en, 1);
    wr(8'h05, 8'hFF);
    rc(8'h0A, 8'h00);
    wr(8'h06, 8'hFF);
    chk("irq", {pg_irq, eoc_irq, phase_irq, therm_irq, bovp_irq, battery_switch_on}, 0);
    rc(8'h06, 8'h7F);
    chk("double", safety_timer_double_en, 1);
    wr(8'h06, 8'h00);
    chk("double", safety_timer_double_en, 0);
    chk("irq", {pg_irq, eoc_irq, phase_irq, therm_irq, bovp_irq, battery_switch_on}, 6'h3F);
    // every junction code and every voltage step
    for (int k = 0; k < 16; k++)
    begin
      wr(8'h07, {2'h0, k[1:0], k[3:0]});
      chk("sysv", {junction_limit_sel, system_voltage_mv}, {k[1:0], 16'(4200 + 50 * k)});
    end
    wr(8'h07, 8'hFF);
    chk("pwr", {low_power_enable, input_loop_disable, system_voltage_code}, 6'h3F);
    // status is read-only: writes in between must not stick
    for (int p = 0; p < 5; p++)
    begin
      {charge_phase, power_path_active, input_power_good, thermal_regulating} = {p[2:0], 3'h5};
      wr(8'h08, 8'hFF);
      rc(8'h08, {2'h0, p[2:0], 3'h5});
    end
    for (int t = 0; t < 6; t++)
    begin
      {input_fault_flag, overheat_shutdown_flag, battery_overvolt_flag, safety_timeout_flag} = 4'hA ^ t;
      thermistor_fault_code = t[2:0];
      wr(8'h09, 8'h7F);
      rc(8'h09, {1'h0, 4'hA ^ t[3:0], t[2:0]});
    end
    wr(8'h06, 8'h3F);
    wr(8'h09, 8'h80);
    @(posedge ref_clk);
    rc(8'h06, 8'h40);
    rc(8'h07, 8'h39);
    rc(8'h09, 8'h7D);
    // watchdog: 40 s at ten ticks a second, restarted by the same write
    wr(8'h07, 8'h40);
    dog_limit_sel = 2'h1;
    wr(8'h06, 8'hA1);
    for (n = 0; n < 1000 && dog_expiry_event !== 1'h1; n++) @(negedge ref_clk);
    chk("dog", n >= 390 && n <= 410, 1);
    rc(8'h08, 8'hA5);
    rc(8'h06, 8'h60);
    rc(8'h07, 8'h30);
    wr(8'h06, 8'h80);
    rc(8'h08, 8'h25);
    end_sim();
  end
endmodule
